// ### rtl/hbfe_edge.sv
/*
  Edge finder for a group of active-low strobes.
  Assumes the strobes are already synchronous to ref_clk; the idle level is
  high, so the reset value avoids a false rising edge after reset.
*/
`timescale 1ns/100ps
module hbfe_edge #(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] prev;
  } hbfe_edge_state_t;

  hbfe_edge_state_t st_q;
  hbfe_edge_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.prev = level;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{prev: {W{1'b1}}};
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = level & ~st_q.prev;
  assign fall = ~level & st_q.prev;

endmodule

// ### rtl/hbfe_pkg.sv
/*
  Shared constants and types of the host bus front end: register offsets,
  field positions, reset values, strap encodings, state encodings and the
  packed state record of the top module.
  Assumes a single 25 MHz core clock and a 32-bit register port.
*/
package hbfe_pkg;

  localparam int CLK_PERIOD_NS = 40;

  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LATCH = 8'h0c;
  localparam logic [7:0] REG_WDATA = 8'h10;

  // Control register fields
  localparam int CTRL_MDIX_BIT = 0;
  localparam logic CTRL_MDIX_RST = 1'b0;

  // Base address register; bits 15:4 are compared against A15-A4
  localparam int BASE_W = 16;
  localparam int BASE_CMP_LSB = 4;
  localparam logic [15:0] BASE_RST = 16'h0300;

  // Status register fields
  localparam int STAT_WIDTH_LSB = 0;
  localparam int STAT_SYNC_BIT = 2;
  localparam int STAT_CFGMEM_BIT = 3;
  localparam int STAT_SLEEP_BIT = 4;
  localparam int STAT_LAT_AEN_BIT = 5;
  localparam int STAT_TAKEN_BIT = 6;
  localparam int STAT_MDIX_BIT = 7;

  typedef enum logic [1:0] {
    HBFE_W8 = 2'b00,
    HBFE_W16 = 2'b01,
    HBFE_W32 = 2'b10
  } hbfe_width_t;

  typedef enum logic [1:0] {
    HBFE_ST_SAMPLE = 2'b00,
    HBFE_ST_RUN = 2'b01,
    HBFE_ST_SLEEP = 2'b10
  } hbfe_fsm_t;

  typedef struct packed {
    logic taken;
    logic cfg_present;
    logic sync_mode;
    hbfe_width_t width;
  } hbfe_straps_t;

  localparam hbfe_straps_t STRAPS_RST = '{
    taken: 1'b0, cfg_present: 1'b0, sync_mode: 1'b1, width: HBFE_W16};

  // One differential line pair: both pin levels
  typedef struct packed {
    logic pos;
    logic neg;
  } hbfe_diff_t;

  typedef struct packed {
    hbfe_fsm_t fsm;
    hbfe_straps_t straps;
    logic mdix;
    logic [15:0] base;
    logic [15:1] lat_addr;
    logic lat_aen;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ldev_n;
    logic host_wr;
    logic host_rd;
    logic sync_wr;
    logic sync_rd;
    logic cfg_bit;
    logic cfg_bit_valid;
    hbfe_diff_t rx;
    hbfe_diff_t a_out;
    logic a_oe;
    hbfe_diff_t b_out;
    logic b_oe;
    logic asleep;
  } hbfe_state_t;

endpackage

// ### rtl/hbfe_top.sv
/*
  Host bus front end: strap sampling, address qualification and decode,
  asynchronous and synchronous strobe handling, address latching, full-chip
  sleep and straight/crossed line pair roles, plus a small register port.
  Assumes every pin input is already synchronous to ref_clk and that the
  straps are stable while reset_n is low and for one edge after release.
*/
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
module hbfe_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  // Straps
  input wire logic cfg_serial_data_in,
  input wire logic cfg_memory_present_strap,
  input wire logic sync_bus_strap_n,
  input wire logic bus32_strap,
  // Config memory engine side
  input wire logic cfg_sample_en,
  output logic cfg_bit,
  output logic cfg_bit_valid,
  // Host bus pins
  input wire logic sync_dir_select,
  input wire logic addr_qualifier_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic addr_latch_strobe_n,
  input wire logic [15:1] host_addr,
  input wire logic [31:0] host_data_in,
  input wire logic chip_sleep_n,
  output logic local_select_n,
  // Events and captured values toward the core
  output logic host_wr_pulse,
  output logic host_rd_pulse,
  output logic sync_wr_pulse,
  output logic sync_rd_pulse,
  output logic [31:0] host_wdata,
  output logic [15:1] latched_addr,
  output logic latched_qualifier_n,
  output logic [1:0] bus_width,
  output logic sync_mode,
  output logic cfg_mem_enabled,
  output logic chip_asleep,
  // Line pins and core side of the line
  input wire logic line_pair_a_pos_in,
  input wire logic line_pair_a_neg_in,
  output logic line_pair_a_pos_out,
  output logic line_pair_a_neg_out,
  output logic line_pair_a_pos_oe,
  output logic line_pair_a_neg_oe,
  input wire logic line_pair_b_pos_in,
  input wire logic line_pair_b_neg_in,
  output logic line_pair_b_pos_out,
  output logic line_pair_b_neg_out,
  output logic line_pair_b_pos_oe,
  output logic line_pair_b_neg_oe,
  input wire logic line_tx_pos,
  input wire logic line_tx_neg,
  output logic line_rx_pos,
  output logic line_rx_neg,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  hbfe_pkg::hbfe_state_t st_q;
  hbfe_pkg::hbfe_state_t st_d;

  logic [2:0] strobe_rise;
  logic [2:0] strobe_fall;

  // Bit 0 write, bit 1 read, bit 2 address strobe
  hbfe_edge #(
    .W(3)
  ) u_edge (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .level({addr_latch_strobe_n, read_strobe_n, write_strobe_n}),
    .rise(strobe_rise),
    .fall(strobe_fall)
  );

  // Qualified match of A15-A4 against the programmed base
  function automatic logic addr_hit(
    input logic qual_n,
    input logic [15:1] addr,
    input logic [15:0] base
  );
    addr_hit = !qual_n && (addr[15:4] == base[15:4]);
  endfunction

  function automatic hbfe_pkg::hbfe_width_t pick_width(
    input logic w32,
    input logic cfg_present,
    input logic data_strap
  );
    if (w32) begin
      pick_width = hbfe_pkg::HBFE_W32;
    end else if (cfg_present) begin
      // Width then comes from the memory image; bus_width stays 16-bit, as it is never reloaded here
      pick_width = hbfe_pkg::HBFE_W16;
    end else if (data_strap) begin
      pick_width = hbfe_pkg::HBFE_W16;
    end else begin
      pick_width = hbfe_pkg::HBFE_W8;
    end
  endfunction

  function automatic logic [31:0] status_word(
    input hbfe_pkg::hbfe_state_t s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[hbfe_pkg::STAT_WIDTH_LSB +: 2] = s.straps.width;
    w[hbfe_pkg::STAT_SYNC_BIT] = s.straps.sync_mode;
    w[hbfe_pkg::STAT_CFGMEM_BIT] = s.straps.cfg_present;
    w[hbfe_pkg::STAT_SLEEP_BIT] = s.asleep;
    w[hbfe_pkg::STAT_LAT_AEN_BIT] = s.lat_aen;
    w[hbfe_pkg::STAT_TAKEN_BIT] = s.straps.taken;
    w[hbfe_pkg::STAT_MDIX_BIT] = s.mdix;
    status_word = w;
  endfunction

  logic hit;
  logic awake;

  always_comb begin
    st_d = st_q;
    hit = addr_hit(addr_qualifier_n, host_addr, st_q.base);
    awake = (st_q.fsm == hbfe_pkg::HBFE_ST_RUN);

    st_d.host_wr = 1'b0;
    st_d.host_rd = 1'b0;
    st_d.sync_wr = 1'b0;
    st_d.sync_rd = 1'b0;
    st_d.cfg_bit_valid = 1'b0;
    st_d.rdata = 32'h0000_0000;

    case (st_q.fsm)
      hbfe_pkg::HBFE_ST_SAMPLE: begin
        // First edge after release: straps are taken here and never again
        st_d.straps.taken = 1'b1;
        st_d.straps.cfg_present = cfg_memory_present_strap;
        st_d.straps.sync_mode = !sync_bus_strap_n;
        st_d.straps.width = pick_width(bus32_strap,
          cfg_memory_present_strap, cfg_serial_data_in);
        st_d.fsm = hbfe_pkg::HBFE_ST_RUN;
      end
      hbfe_pkg::HBFE_ST_RUN: begin
        if (!chip_sleep_n) begin
          st_d.fsm = hbfe_pkg::HBFE_ST_SLEEP;
        end
      end
      hbfe_pkg::HBFE_ST_SLEEP: begin
        if (chip_sleep_n) begin
          st_d.fsm = hbfe_pkg::HBFE_ST_RUN;
        end
      end
      default: begin
        st_d.fsm = hbfe_pkg::HBFE_ST_SAMPLE;
      end
    endcase

    st_d.asleep = (st_d.fsm == hbfe_pkg::HBFE_ST_SLEEP);

    // Decode is live; it is still held high while asleep
    st_d.ldev_n = !(hit && awake);

    // Address latch works in both bus modes, but only while awake
    if (awake && strobe_rise[2]) begin
      st_d.lat_addr = host_addr;
      st_d.lat_aen = addr_qualifier_n;
    end

    if (awake && !st_q.straps.sync_mode) begin
      if (strobe_fall[0] && hit) begin
        st_d.host_wr = 1'b1;
        st_d.wdata = host_data_in;
      end
      if (strobe_fall[1] && hit) begin
        st_d.host_rd = 1'b1;
      end
    end

    // Synchronous cycle is called at the end of the address phase
    if (awake && st_q.straps.sync_mode && strobe_rise[2] && hit) begin
      if (sync_dir_select) begin
        st_d.sync_wr = 1'b1;
        st_d.wdata = host_data_in;
      end else begin
        st_d.sync_rd = 1'b1;
      end
    end

    // Serial read data from the config memory, only when it is fitted
    if (st_q.straps.cfg_present && cfg_sample_en && awake) begin
      st_d.cfg_bit = cfg_serial_data_in;
      st_d.cfg_bit_valid = 1'b1;
    end

    // Line pair roles; all drivers released while asleep
    st_d.a_oe = awake && st_q.mdix;
    st_d.b_oe = awake && !st_q.mdix;
    st_d.a_out = '{pos: line_tx_pos, neg: line_tx_neg};
    st_d.b_out = '{pos: line_tx_pos, neg: line_tx_neg};
    if (!awake) begin
      st_d.rx = '{pos: 1'b0, neg: 1'b0};
    end else if (st_q.mdix) begin
      st_d.rx = '{pos: line_pair_b_pos_in, neg: line_pair_b_neg_in};
    end else begin
      st_d.rx = '{pos: line_pair_a_pos_in, neg: line_pair_a_neg_in};
    end

    // Register port stays alive during sleep so software can inspect it
    if (reg_wr) begin
      case (reg_addr)
        hbfe_pkg::REG_CTRL: begin
          st_d.mdix = reg_wdata[hbfe_pkg::CTRL_MDIX_BIT];
        end
        hbfe_pkg::REG_BASE: begin
          st_d.base = reg_wdata[hbfe_pkg::BASE_W-1:0];
        end
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        hbfe_pkg::REG_CTRL: begin
          st_d.rdata = {31'h0000_0000, st_q.mdix};
        end
        hbfe_pkg::REG_BASE: begin
          st_d.rdata = {16'h0000, st_q.base};
        end
        hbfe_pkg::REG_STATUS: begin
          st_d.rdata = status_word(st_q);
        end
        hbfe_pkg::REG_LATCH: begin
          st_d.rdata = {16'h0000, st_q.lat_addr, 1'b0};
        end
        hbfe_pkg::REG_WDATA: begin
          st_d.rdata = st_q.wdata;
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{
        fsm: hbfe_pkg::HBFE_ST_SAMPLE,
        straps: hbfe_pkg::STRAPS_RST,
        mdix: hbfe_pkg::CTRL_MDIX_RST,
        base: hbfe_pkg::BASE_RST,
        lat_addr: 15'h0000,
        lat_aen: 1'b1,
        wdata: 32'h0000_0000,
        rdata: 32'h0000_0000,
        ldev_n: 1'b1,
        host_wr: 1'b0,
        host_rd: 1'b0,
        sync_wr: 1'b0,
        sync_rd: 1'b0,
        cfg_bit: 1'b0,
        cfg_bit_valid: 1'b0,
        rx: '{pos: 1'b0, neg: 1'b0},
        a_out: '{pos: 1'b0, neg: 1'b0},
        a_oe: 1'b0,
        b_out: '{pos: 1'b0, neg: 1'b0},
        b_oe: 1'b0,
        asleep: 1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_bit = st_q.cfg_bit;
  assign cfg_bit_valid = st_q.cfg_bit_valid;
  assign local_select_n = st_q.ldev_n;
  assign host_wr_pulse = st_q.host_wr;
  assign host_rd_pulse = st_q.host_rd;
  assign sync_wr_pulse = st_q.sync_wr;
  assign sync_rd_pulse = st_q.sync_rd;
  assign host_wdata = st_q.wdata;
  assign latched_addr = st_q.lat_addr;
  assign latched_qualifier_n = st_q.lat_aen;
  assign bus_width = st_q.straps.width;
  assign sync_mode = st_q.straps.sync_mode;
  assign cfg_mem_enabled = st_q.straps.cfg_present;
  assign chip_asleep = st_q.asleep;
  assign line_pair_a_pos_out = st_q.a_out.pos;
  assign line_pair_a_neg_out = st_q.a_out.neg;
  assign line_pair_a_pos_oe = st_q.a_oe;
  assign line_pair_a_neg_oe = st_q.a_oe;
  assign line_pair_b_pos_out = st_q.b_out.pos;
  assign line_pair_b_neg_out = st_q.b_out.neg;
  assign line_pair_b_pos_oe = st_q.b_oe;
  assign line_pair_b_neg_oe = st_q.b_oe;
  assign line_rx_pos = st_q.rx.pos;
  assign line_rx_neg = st_q.rx.neg;
  assign reg_rdata = st_q.rdata;

endmodule

// ### tb/hbfe_host.sv
/*
  Host CPU model driving the host bus pins of hbfe_top.
  Assumes the bench calls access() from one process at a time.
*/
`timescale 1ns/100ps
module hbfe_host (
  input wire logic ref_clk,
  output logic sync_dir_select,
  output logic addr_qualifier_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic addr_latch_strobe_n,
  output logic [15:1] host_addr,
  output logic [31:0] host_data_in
);
  initial begin
    sync_dir_select = 1'b0;
    addr_qualifier_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    addr_latch_strobe_n = 1'b1;
    host_addr = '0;
    host_data_in = '0;
  end
  // Kind 0/1 async write/read, 2/3 latched cycle writing/reading
  task automatic access(input int k, input logic q, input logic [15:1] a,
      input logic [31:0] x);
    @(posedge ref_clk);
    addr_qualifier_n <= q;
    host_addr <= a;
    host_data_in <= x;
    sync_dir_select <= (k == 2);
    @(posedge ref_clk);
    write_strobe_n <= (k != 0);
    read_strobe_n <= (k != 1);
    addr_latch_strobe_n <= (k < 2);
    @(posedge ref_clk);
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    addr_latch_strobe_n <= 1'b1;
    @(posedge ref_clk);
    // Released lines show the inverse so stale values cannot pass
    addr_qualifier_n <= 1'b1;
    host_addr <= ~a;
    host_data_in <= ~x;
    sync_dir_select <= ~sync_dir_select;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// ### tb/hbfe_properties.sv
/*
  Checker for the host bus front end, bound to hbfe_top.
  Sees only top-level ports; one clock domain, reset active low.
*/
`timescale 1ns/100ps
module hbfe_properties (
  input logic ref_clk,
  input logic reset_n,
  input logic cfg_serial_data_in,
  input logic cfg_memory_present_strap,
  input logic sync_bus_strap_n,
  input logic bus32_strap,
  input logic cfg_sample_en,
  input logic cfg_bit,
  input logic cfg_bit_valid,
  input logic sync_dir_select,
  input logic addr_qualifier_n,
  input logic write_strobe_n,
  input logic read_strobe_n,
  input logic addr_latch_strobe_n,
  input logic [15:1] host_addr,
  input logic [31:0] host_data_in,
  input logic chip_sleep_n,
  input logic local_select_n,
  input logic host_wr_pulse,
  input logic host_rd_pulse,
  input logic sync_wr_pulse,
  input logic sync_rd_pulse,
  input logic [31:0] host_wdata,
  input logic [15:1] latched_addr,
  input logic latched_qualifier_n,
  input logic [1:0] bus_width,
  input logic sync_mode,
  input logic cfg_mem_enabled,
  input logic chip_asleep,
  input logic line_pair_a_pos_oe,
  input logic line_pair_b_pos_oe
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Straps are taken at the first edge after release
  AST_STRAP_TAKE: assert property (
    $past(reset_n) && !$past(reset_n, 2) |-> bus_width == ($past(bus32_strap)
    ? 2'b10 : $past(cfg_memory_present_strap) ? 2'b01
    : {1'b0, $past(cfg_serial_data_in)}) && sync_mode == !$past(sync_bus_strap_n)
    && cfg_mem_enabled == $past(cfg_memory_present_strap))
    else $error("strap sample wrong");
  AST_STRAP_HOLD: assert property (
    $past(reset_n) && $past(reset_n, 2)
    |-> $stable({bus_width, sync_mode, cfg_mem_enabled}))
    else $error("strap value moved");
  AST_WR: assert property (
    host_wr_pulse |-> !$past(write_strobe_n) && $past(write_strobe_n, 2)
    && !$past(addr_qualifier_n) && !sync_mode
    && host_wdata == $past(host_data_in)) else $error("bad write pulse");
  AST_RD: assert property (
    host_rd_pulse |-> !$past(read_strobe_n) && $past(read_strobe_n, 2)
    && !$past(addr_qualifier_n) && !sync_mode) else $error("bad read pulse");
  AST_SWR: assert property (
    sync_wr_pulse |-> sync_mode && $past(sync_dir_select)
    && $past(addr_latch_strobe_n) && !$past(addr_latch_strobe_n, 2)
    && !$past(addr_qualifier_n)) else $error("bad sync write");
  AST_SRD: assert property (
    sync_rd_pulse |-> sync_mode && !$past(sync_dir_select)
    && !$past(addr_qualifier_n)) else $error("bad sync read");
  AST_LATCH: assert property (
    $rose(addr_latch_strobe_n) && !chip_asleep && chip_sleep_n
    |=> latched_addr == $past(host_addr)
    && latched_qualifier_n == $past(addr_qualifier_n))
    else $error("latch missed");
  AST_SEL: assert property (
    !local_select_n |-> !$past(addr_qualifier_n)) else $error("bad select");
  AST_SLEEP: assert property (
    1'b1 |=> chip_asleep == !$past(chip_sleep_n)) else $error("sleep late");
  AST_QUIET: assert property (
    chip_asleep && $past(chip_asleep) |-> !line_pair_a_pos_oe
    && !line_pair_b_pos_oe && !host_wr_pulse) else $error("active asleep");
  AST_CFG: assert property (
    cfg_sample_en && cfg_mem_enabled && !chip_asleep && chip_sleep_n
    |=> cfg_bit_valid && cfg_bit == $past(cfg_serial_data_in))
    else $error("config bit lost");
  AST_CFG_OFF: assert property (
    cfg_bit_valid |-> cfg_mem_enabled) else $error("config bit unasked");

  cover property (host_wr_pulse);
  cover property (sync_rd_pulse);
  cover property (chip_asleep && $past(chip_asleep));
endmodule

bind hbfe_top hbfe_properties hbfe_properties_inst (.*);

// ### tb/testbench.sv
/*
  Self-checking bench for hbfe_top with the host model on the bus pins.
  Line pins resolve from the design's enables and far-side levels.
*/
`timescale 1ns/100ps
module testbench;
  logic ref_clk, reset_n, cfg_serial_data_in, cfg_memory_present_strap;
  logic sync_bus_strap_n, bus32_strap, cfg_sample_en, cfg_bit, cfg_bit_valid;
  logic sync_dir_select, addr_qualifier_n, write_strobe_n, read_strobe_n;
  logic addr_latch_strobe_n, chip_sleep_n, local_select_n, chip_asleep;
  logic host_wr_pulse, host_rd_pulse, sync_wr_pulse, sync_rd_pulse;
  logic [15:1] host_addr, latched_addr;
  logic [31:0] host_data_in, host_wdata, reg_wdata, reg_rdata, v, d;
  logic latched_qualifier_n, sync_mode, cfg_mem_enabled, reg_wr, reg_rd;
  logic [1:0] bus_width;
  logic [7:0] reg_addr;
  logic [15:0] base;
  logic [3:0] fa;
  logic line_pair_a_pos_in, line_pair_a_neg_in, line_pair_a_pos_out;
  logic line_pair_a_neg_out, line_pair_a_pos_oe, line_pair_a_neg_oe;
  logic line_pair_b_pos_in, line_pair_b_neg_in, line_pair_b_pos_out;
  logic line_pair_b_neg_out, line_pair_b_pos_oe, line_pair_b_neg_oe;
  logic line_tx_pos, line_tx_neg, line_rx_pos, line_rx_neg;
  int errors = 0, total_checks = 0, nwr = 0, nrd = 0, nswr = 0, nsrd = 0;
  logic [3:0] st [5] = '{4'h0, 4'h1, 4'h4, 4'h9, 4'h2};

  assign line_pair_a_pos_in = line_pair_a_pos_oe ? line_pair_a_pos_out : fa[3];
  assign line_pair_a_neg_in = line_pair_a_neg_oe ? line_pair_a_neg_out : fa[2];
  assign line_pair_b_pos_in = line_pair_b_pos_oe ? line_pair_b_pos_out : fa[1];
  assign line_pair_b_neg_in = line_pair_b_neg_oe ? line_pair_b_neg_out : fa[0];

  hbfe_top hbfe_top_inst (.*);
  hbfe_host hbfe_host_inst (.*);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    nwr += (host_wr_pulse === 1'b1);
    nrd += (host_rd_pulse === 1'b1);
    nswr += (sync_wr_pulse === 1'b1);
    nsrd += (sync_rd_pulse === 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Strap word: {32-bit, memory fitted, async, serial data}
  function automatic logic [1:0] exp_w(input logic [3:0] s);
    return s[3] ? 2'b10 : s[2] ? 2'b01 : {1'b0, s[0]};
  endfunction

  task automatic rst(input logic [3:0] s);
    {bus32_strap, cfg_memory_present_strap, sync_bus_strap_n,
      cfg_serial_data_in} <= s;
    reset_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    {bus32_strap, cfg_memory_present_strap, sync_bus_strap_n} = 3'h0;
    {cfg_serial_data_in, cfg_sample_en, chip_sleep_n} = 3'h1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {fa, line_tx_pos, line_tx_neg} = '0;
    void'($urandom(12));
    foreach (st[i]) begin
      rst(st[i]);
      chk(bus_width, exp_w(st[i]));
      chk(sync_mode, !st[i][1]);
      chk(cfg_mem_enabled, st[i][2]);
      {bus32_strap, cfg_memory_present_strap, sync_bus_strap_n,
        cfg_serial_data_in} <= ~st[i];
      repeat (2) @(posedge ref_clk);
      chk(bus_width, exp_w(st[i]));
      if (st[i][2]) begin
        v = $urandom;
        cfg_sample_en <= 1'b1;
        cfg_serial_data_in <= v[0];
        @(posedge ref_clk);
        cfg_sample_en <= 1'b0;
        #1 chk(cfg_bit_valid, 1'b1);
        repeat (2) @(posedge ref_clk);
        chk(cfg_bit, v[0]);
      end
    end
    $display("strap test done");
    rst(4'h2);
    rd(hbfe_pkg::REG_BASE, v);
    chk(v[15:0], hbfe_pkg::BASE_RST);
    rd(8'h20, v);
    chk(v, 32'h0);
    base = $urandom;
    wr(hbfe_pkg::REG_BASE, {16'h0, base});
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      v = $urandom;
      hbfe_host_inst.access(i % 2, 1'b0, {base[15:4], v[2:0]}, d);
      if (i % 2 == 0) chk(host_wdata, d);
    end
    chk(nrd, 4);
    hbfe_host_inst.access(0, 1'b1, {base[15:4], 3'h0}, d);
    hbfe_host_inst.access(0, 1'b0, {base[15:4] ^ 12'h001, 3'h0}, d);
    chk(nwr, 4);
    chip_sleep_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(chip_asleep, 1'b1);
    hbfe_host_inst.access(0, 1'b0, {base[15:4], 3'h0}, d);
    chk(nwr, 4);
    chk({line_pair_a_pos_oe, line_pair_b_pos_oe}, 2'b00);
    chip_sleep_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(chip_asleep, 1'b0);
    $display("async test done");
    for (int m = 0; m < 2; m++) begin
      wr(hbfe_pkg::REG_CTRL, 32'(m));
      repeat (4) begin
        v = $urandom;
        fa <= v[3:0];
        {line_tx_pos, line_tx_neg} <= v[5:4];
        repeat (3) @(posedge ref_clk);
        d[1:0] = m ? {line_pair_a_pos_out, line_pair_a_neg_out}
          : {line_pair_b_pos_out, line_pair_b_neg_out};
        chk({line_rx_pos, line_rx_neg}, m ? v[1:0] : v[3:2]);
        chk(d[1:0], v[5:4]);
        chk({line_pair_a_pos_oe, line_pair_b_pos_oe}, m ? 2'b10 : 2'b01);
      end
    end
    $display("line test done");
    rst(4'h0);
    rd(hbfe_pkg::REG_STATUS, v);
    chk(v, (32'h1 << hbfe_pkg::STAT_TAKEN_BIT) |
      (32'h1 << hbfe_pkg::STAT_SYNC_BIT) |
      (32'h1 << hbfe_pkg::STAT_LAT_AEN_BIT));
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      v = $urandom;
      hbfe_host_inst.access(2 + i % 2, 1'b0,
        {hbfe_pkg::BASE_RST[15:4], v[2:0]}, d);
      chk(latched_addr, {hbfe_pkg::BASE_RST[15:4], v[2:0]});
      if (i % 2 == 0) chk(host_wdata, d);
    end
    chk(nswr, 2);
    chk(nsrd, 2);
    hbfe_host_inst.access(2, 1'b1, {hbfe_pkg::BASE_RST[15:4], 3'h1}, d);
    chk(latched_qualifier_n, 1'b1);
    chk(nswr, 2);
    hbfe_host_inst.access(0, 1'b0, {hbfe_pkg::BASE_RST[15:4], 3'h0}, d);
    chk(nwr, 4);
    // Hold a matching, qualified address so the decode can be seen standing
    hbfe_host_inst.host_addr <= {hbfe_pkg::BASE_RST[15:4], 3'h2};
    hbfe_host_inst.addr_qualifier_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(local_select_n, 1'b0);
    hbfe_host_inst.addr_qualifier_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(local_select_n, 1'b1);
    $display("sync test done");
    close_out();
  end
endmodule
